// File: hdl/lane_rm_cfg.svh
// offsets, field positions, reset values and symbol codes of the lane block
`ifndef LANE_RM_CFG_SVH
`define LANE_RM_CFG_SVH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_IRQ_STAT  12'h008
`define OFF_IRQ_MASK  12'h00C
// ----------------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_LOWLAT   0
`define CTRL_INFER    1
`define CTRL_RST      2'h0
`define MASK_RST      6'h00
// ----------------------------------------------------------------------------
// event bits of the interrupt status register
// ----------------------------------------------------------------------------
`define EV_SYNC_UP    0
`define EV_SYNC_DN    1
`define EV_INS        2
`define EV_DEL        3
`define EV_OVF        4
`define EV_UDF        5
`define EV_W          6
// ----------------------------------------------------------------------------
// symbols, sync counts and pipe status codes
// ----------------------------------------------------------------------------
`define COMMA_RDN     10'h0FA
`define COMMA_RDP     10'h305
`define SYM_COM       8'hBC
`define SYM_SKP       8'h1C
`define SKP_MAX       3'h5
`define SYNC_COMMAS   3'h4
`define LOSE_ERRS     5'h11
`define GOOD_RUN      5'h10
`define PST_OK        3'h0
`define PST_INS       3'h1
`define PST_DEL       3'h2
`endif

// File: hdl/lane_rm_pkg.sv
// types shared by the lane sync and rate match block
package lane_rm_pkg;
  typedef enum logic {ST_SEEK, ST_SYNC} sync_state_e;
  typedef logic [2:0] pipe_stat_t;
endpackage : lane_rm_pkg

// File: hdl/lane_sync_rm.sv
// lane synchronisation, rate match fifo and apb register file
`timescale 1ns/1ps
`include "lane_rm_cfg.svh"

// How it works
// RL1: fabric feeds a 125 MHz receiver detect clock; outside this block.
// RL2: three fabric clocks are driven out: transmit, receive and bonded.
// RL3: fabric feeds a separate reconfiguration clock; outside this block.
// RL4: without idle inference, idle output is the inverse of signal detect.
// RL5: four valid commas move the lane to synchronised.
// RL6: error count reaching seventeen drops synchronisation.
// RL7: sixteen good groups in a row lower the error count by one.
// RL8: comma search compares whole ten-bit code groups.
// RL9: fifo margins absorb plus or minus 300 ppm clock offset.
// RL10: at most one skip inserted or deleted per skip ordered set.
// RL11: skip set is one comma then one to five skip symbols.
// RL12: rate matching runs only while sync status is high.
// RL13: every insert and delete shows on the three-bit pipe status.
// RL14: low-latency mode bypasses the fifo for common-clock links.
// RL15: losing sync clears errors and restarts the comma search.
module lane_sync_rm #(
  parameter int DEPTH = 8
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    sym_valid,
  input  wire logic [9:0]              sym_raw,
  input  wire logic [7:0]              sym_data,
  input  wire logic                    sym_k,
  input  wire logic                    sym_err,
  input  wire logic                    sig_detect,
  input  wire logic                    out_ready,
  output logic                         out_valid,
  output logic      [7:0]              out_data,
  output logic                         out_k,
  output lane_rm_pkg::pipe_stat_t      pipe_status,
  output logic                         sync_status,
  output logic                         elec_idle,
  output logic                         irq,
  output logic                         tx_clk_out,
  output logic                         rx_clk_out,
  output logic                         core_clk_out
);
  import lane_rm_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  // margins sized so a 600 ppm total offset never crosses full or empty
  localparam logic [CW-1:0] LO_MARK = CW'(DEPTH / 4);  // see RL9
  localparam logic [CW-1:0] HI_MARK = CW'(DEPTH - DEPTH / 4);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("DEPTH must be a power of two of at least 4");
  end

  // --------------------------------------------------------------------------
  // fabric clocks and signal detect
  // --------------------------------------------------------------------------
  logic div_q;
  // one divider feeds all three so they stay phase aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q        <= 1'b0;
      tx_clk_out   <= 1'b0;
      rx_clk_out   <= 1'b0;
      core_clk_out <= 1'b0;
    end else begin
      div_q        <= ~div_q;
      tx_clk_out   <= ~div_q;  // see RL2
      rx_clk_out   <= ~div_q;  // see RL2
      core_clk_out <= ~div_q;  // see RL2
    end
  end

  logic sd1_q, sd2_q, sd3_q, sd_lvl_q;
  // pin passes three flops; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd1_q    <= 1'b0;
      sd2_q    <= 1'b0;
      sd3_q    <= 1'b0;
      sd_lvl_q <= 1'b0;
    end else begin
      sd1_q <= sig_detect;
      sd2_q <= sd1_q;
      sd3_q <= sd2_q;
      if (sd2_q == sd3_q)
        sd_lvl_q <= sd3_q;
    end
  end

  logic [1:0] ctrl_q;
  // idle inference falls back on sync state when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      elec_idle <= 1'b1;
    else if (!ctrl_q[`CTRL_INFER])
      elec_idle <= ~sd_lvl_q;  // see RL4
    else
      elec_idle <= ~sync_status;
  end

  // --------------------------------------------------------------------------
  // synchronisation state machine
  // --------------------------------------------------------------------------
  sync_state_e st_q;
  logic [2:0]  comma_cnt_q;
  logic [4:0]  err_cnt_q;
  logic [4:0]  good_cnt_q;
  logic        is_comma, bad, ev_up, ev_dn;

  assign is_comma = (sym_raw == `COMMA_RDN) || (sym_raw == `COMMA_RDP);  // see RL8
  assign bad      = sym_valid && sym_err;
  assign ev_up    = (st_q == ST_SEEK) && sym_valid && is_comma && !sym_err
                    && (comma_cnt_q == `SYNC_COMMAS - 3'h1);
  assign ev_dn    = (st_q == ST_SYNC) && bad && (err_cnt_q == `LOSE_ERRS - 5'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= ST_SEEK;
      comma_cnt_q <= 3'h0;
      err_cnt_q   <= 5'h00;
      good_cnt_q  <= 5'h00;
    end else begin
      unique case (st_q)
        ST_SEEK: begin
          if (ev_up) begin
            st_q        <= ST_SYNC;  // see RL5
            comma_cnt_q <= 3'h0;
          end else if (bad)
            comma_cnt_q <= 3'h0;
          else if (sym_valid && is_comma)
            comma_cnt_q <= comma_cnt_q + 3'h1;
        end
        ST_SYNC: begin
          if (ev_dn) begin
            st_q       <= ST_SEEK;  // see RL6
            err_cnt_q  <= 5'h00;    // see RL15
            good_cnt_q <= 5'h00;
          end else if (bad) begin
            err_cnt_q  <= err_cnt_q + 5'h01;
            good_cnt_q <= 5'h00;
          end else if (sym_valid) begin
            if (good_cnt_q == `GOOD_RUN - 5'h01) begin
              good_cnt_q <= 5'h00;
              if (err_cnt_q != 5'h00)
                err_cnt_q <= err_cnt_q - 5'h01;  // see RL7
            end else
              good_cnt_q <= good_cnt_q + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sync_status <= 1'b0;
    else
      sync_status <= (st_q == ST_SYNC && !ev_dn) || ev_up;  // see RL15
  end

  // --------------------------------------------------------------------------
  // rate match fifo
  // --------------------------------------------------------------------------
  logic [9:0]    mem_q [DEPTH];  // bit 9 marks a comma whose set lost a skip
  logic [AW-1:0] wp_q, rp_q, com_wp_q;
  logic [CW-1:0] cnt_q;
  logic [2:0]    skp_run_q;
  logic          ins_done_q, del_done_q;
  logic          rm_en, in_skp, head_skp, head_com;
  logic          push, pop, ev_ins, ev_del, ev_ovf, ev_udf;

  // matching waits for sync and stays out of the low-latency path
  assign rm_en    = sync_status && !ctrl_q[`CTRL_LOWLAT];  // see RL12
  // a skip counts only inside a set, and only the first five after the comma
  assign in_skp   = sym_valid && sym_k && sym_data == `SYM_SKP
                    && skp_run_q != 3'h0 && skp_run_q <= `SKP_MAX;  // see RL11
  assign head_skp = mem_q[rp_q][8:0] == {1'b1, `SYM_SKP};
  assign head_com = mem_q[rp_q][8:0] == {1'b1, `SYM_COM};
  assign ev_del   = rm_en && in_skp && !del_done_q && cnt_q > HI_MARK;  // see RL10
  assign ev_ins   = rm_en && out_ready && head_skp && !ins_done_q
                    && cnt_q != '0 && cnt_q < LO_MARK;  // see RL10
  assign ev_ovf   = push && cnt_q == CW'(DEPTH) && !pop;
  assign push     = sym_valid && !ctrl_q[`CTRL_LOWLAT] && !ev_del;
  assign pop      = out_ready && cnt_q != '0 && !ev_ins && !ctrl_q[`CTRL_LOWLAT];
  assign ev_udf   = out_ready && cnt_q == '0 && !ctrl_q[`CTRL_LOWLAT] && sync_status;

  // overflowing writes are dropped rather than corrupting the head
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q     <= '0;
      rp_q     <= '0;
      com_wp_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push && !ev_ovf)
        wp_q <= wp_q + AW'(1);
      if (push && !ev_ovf && sym_k && sym_data == `SYM_COM)
        com_wp_q <= wp_q;
      if (pop)
        rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + CW'(push && !ev_ovf) - CW'(pop);
    end
  end

  // a deletion tags its set's comma so the read side cannot also insert
  always_ff @(posedge pclk) begin
    if (push && !ev_ovf)
      mem_q[wp_q] <= {1'b0, sym_k, sym_data};
    else if (ev_del)
      mem_q[com_wp_q][9] <= 1'b1;  // see RL10
  end

  // per-set bookkeeping; a comma opens a new set and rearms deletion, and rearms insertion at the head unless tagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skp_run_q  <= 3'h0;
      del_done_q <= 1'b0;
      ins_done_q <= 1'b0;
    end else begin
      if (sym_valid) begin
        if (sym_k && sym_data == `SYM_COM) begin
          skp_run_q  <= 3'h1;
          del_done_q <= 1'b0;
        end else if (in_skp) begin
          skp_run_q <= skp_run_q + 3'h1;
          if (ev_del)
            del_done_q <= 1'b1;
        end else
          skp_run_q <= 3'h0;
      end
      if (pop && head_com)
        ins_done_q <= mem_q[rp_q][9];  // see RL10
      else if (ev_ins)
        ins_done_q <= 1'b1;
    end
  end

  // low-latency path skips the fifo for common-clock links
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_k     <= 1'b0;
    end else if (ctrl_q[`CTRL_LOWLAT]) begin
      out_valid <= sym_valid;  // see RL14
      out_data  <= sym_data;
      out_k     <= sym_k;
    end else begin
      out_valid <= pop || ev_ins;
      out_data  <= mem_q[rp_q][7:0];
      out_k     <= mem_q[rp_q][8];
    end
  end

  // status is a one-cycle code beside each event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pipe_status <= `PST_OK;
    else if (ev_ins)
      pipe_status <= `PST_INS;  // see RL13
    else if (ev_del)
      pipe_status <= `PST_DEL;  // see RL13
    else
      pipe_status <= `PST_OK;
  end

  // --------------------------------------------------------------------------
  // apb registers and interrupt
  // --------------------------------------------------------------------------
  logic [`EV_W-1:0] stat_q, mask_q, ev;
  logic             acc, wr;

  assign ev  = {ev_udf, ev_ovf, ev_del, ev_ins, ev_dn, ev_up};
  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        unique case (paddr)
          `OFF_CTRL:     prdata <= {30'h0, ctrl_q};
          `OFF_STATUS:   prdata <= {16'h0, 4'(cnt_q), 2'h0, elec_idle,
                                    err_cnt_q, 3'h0, sync_status};
          `OFF_IRQ_STAT: prdata <= {26'h0, stat_q};
          `OFF_IRQ_MASK: prdata <= {26'h0, mask_q};
          default:       pslverr <= 1'b1;
        endcase
      end
    end
  end

  // new events win over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
      mask_q <= `MASK_RST;
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      if (wr && paddr == `OFF_CTRL)
        ctrl_q <= pwdata[1:0];
      if (wr && paddr == `OFF_IRQ_MASK)
        mask_q <= pwdata[`EV_W-1:0];
      if (wr && paddr == `OFF_IRQ_STAT)
        stat_q <= (stat_q & ~pwdata[`EV_W-1:0]) | ev;
      else
        stat_q <= stat_q | ev;
      irq <= |(stat_q & mask_q);
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_comma;
    st_q == ST_SEEK && comma_cnt_q == 3'h3 && sym_valid && is_comma && !sym_err;
  endsequence
  sequence s_last_err;
    st_q == ST_SYNC && err_cnt_q == 5'h10 && bad;
  endsequence

  property p_sync4;
    s_last_comma |=> st_q == ST_SYNC ##1 sync_status;
  endproperty
  a_sync4: assert property (p_sync4) else $error("no sync after four commas"); // see RL5
  property p_lose17;
    s_last_err |=> !sync_status && err_cnt_q == 5'h00 && st_q == ST_SEEK;
  endproperty
  a_lose17: assert property (p_lose17) else $error("sync kept at 17 errors"); // see RL6
  property p_dec16;
    st_q == ST_SYNC && sym_valid && !bad && good_cnt_q == 5'h0F && err_cnt_q != 5'h00
      |=> err_cnt_q == $past(err_cnt_q) - 5'h01;
  endproperty
  a_dec16: assert property (p_dec16) else $error("error count not lowered"); // see RL7
  property p_comma;
    sym_valid && sym_raw == 10'h0FA |-> is_comma;
  endproperty
  a_comma: assert property (p_comma) else $error("ten-bit comma missed"); // see RL8
  property p_one_ins;
    ev_ins |=> !ev_ins ##1 (!ev_ins || $past(pop && head_com));
  endproperty
  a_one_ins: assert property (p_one_ins) else $error("second insert in a set"); // see RL10
  property p_rm_sync;
    (ev_ins || ev_del) |-> sync_status && !ctrl_q[`CTRL_LOWLAT];
  endproperty
  a_rm_sync: assert property (p_rm_sync) else $error("rate match before sync"); // see RL12
  property p_status;
    ev_del && !ev_ins |=> pipe_status == `PST_DEL ##1 pipe_status != `PST_DEL || ev_del;
  endproperty
  a_status: assert property (p_status) else $error("delete not reported"); // see RL13
  property p_idle;
    !ctrl_q[`CTRL_INFER] |=> elec_idle == !$past(sd_lvl_q);
  endproperty
  a_idle: assert property (p_idle) else $error("idle not inverse of detect"); // see RL4
  property p_lowlat;
    ctrl_q[`CTRL_LOWLAT] && sym_valid |=> out_valid && out_data == $past(sym_data);
  endproperty
  a_lowlat: assert property (p_lowlat) else $error("low-latency path broken"); // see RL14
endmodule : lane_sync_rm

// File: testbench/lane_tx_model.sv
// upstream lane transmitter model, one code group per grp call
`timescale 1ns/1ps
`include "lane_rm_cfg.svh"
module lane_tx_model (
  input  wire logic       pclk,
  output logic            sym_valid,
  output logic [9:0]      sym_raw,
  output logic [7:0]      sym_data,
  output logic            sym_k,
  output logic            sym_err
);
  logic rd_q;
  // idle line at time zero
  initial begin
    sym_valid = 1'b0;
    sym_raw   = 10'h2AA;
    sym_data  = 8'h55;
    sym_k     = 1'b0;
    sym_err   = 1'b0;
    rd_q      = 1'b0;
  end
  // one group; commas alternate disparity so both ten-bit forms appear
  task automatic grp(input logic k, input logic [7:0] d, input logic e);
    @(posedge pclk);
    sym_valid <= 1'b1;
    sym_k     <= k;
    sym_data  <= d;
    sym_err   <= e;
    if (k && d == `SYM_COM) begin
      sym_raw <= rd_q ? `COMMA_RDP : `COMMA_RDN;
      rd_q    <= ~rd_q;
    end else begin
      sym_raw <= {2'h1, d};
    end
  endtask : grp
  // released raw and data lines flip every cycle so stale values never look valid
  task automatic gap(input int n);
    repeat (n) begin
      @(posedge pclk);
      sym_valid <= 1'b0;
      sym_raw   <= ~sym_raw;
      sym_data  <= ~sym_data;
    end
  endtask : gap
  // skip set: comma then one to five skips, only between packets
  task automatic skp_set(input int n);
    grp(1'b1, `SYM_COM, 1'b0);
    repeat (n) grp(1'b1, `SYM_SKP, 1'b0);
  endtask : skp_set
endmodule : lane_tx_model

// File: testbench/tb_top.sv
// self-checking bench for the lane sync and rate match block
`timescale 1ns/1ps
`include "lane_rm_cfg.svh"
module tb_top;
  import lane_rm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        sym_valid, sym_k, sym_err, sig_detect, out_ready, out_valid, out_k;
  logic [9:0]  sym_raw;
  logic [7:0]  sym_data, out_data;
  logic [8:0]  expq[$];
  pipe_stat_t  pipe_status;
  logic        sync_status, elec_idle, irq, txc, rxc, cc, chk_en;
  int          err_count, checks_done, skp_out, ins_n, del_n, cyc;

  lane_sync_rm #(.DEPTH(8)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sym_valid(sym_valid), .sym_raw(sym_raw),
    .sym_data(sym_data), .sym_k(sym_k), .sym_err(sym_err), .sig_detect(sig_detect),
    .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data), .out_k(out_k),
    .pipe_status(pipe_status), .sync_status(sync_status), .elec_idle(elec_idle),
    .irq(irq), .tx_clk_out(txc), .rx_clk_out(rxc), .core_clk_out(cc));
  lane_tx_model m (.pclk(pclk), .sym_valid(sym_valid), .sym_raw(sym_raw),
    .sym_data(sym_data), .sym_k(sym_k), .sym_err(sym_err));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // apb transfer; request held until pready is sampled high, cycle guard ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tsym(input logic [7:0] d, input logic e);
    m.grp(1'b0, d, e);
    if (chk_en) expq.push_back({1'b0, d});
  endtask : tsym
  task automatic tset(input int n);
    if (chk_en) expq.push_back({1'b1, `SYM_COM});
    m.skp_set(n);
  endtask : tset
  task automatic settle(input int n);
    m.gap(n);
    #1;
  endtask : settle
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // clock and hang guard; far beyond the ~310 cycles the run needs
  always #5 pclk = ~pclk;  // fabric clocks, only pclk enters this block
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  // reference model: symbols in order, skips counted apart
  always @(posedge pclk) begin
    if (pipe_status === `PST_INS) ins_n++;
    if (pipe_status === `PST_DEL) del_n++;
    if (chk_en && out_valid === 1'b1) begin
      if (out_k === 1'b1 && out_data === `SYM_SKP) skp_out++;
      else if (expq.size() == 0) chk("extra_out", 32'h0, 32'h1);
      else chk("out_sym", 32'(expq.pop_front()), 32'({out_k, out_data}));
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    int k;
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    sig_detect = 1;
    out_ready = 1;
    chk_en = 0;
    k = $urandom(32'h2B81);
    repeat (4) @(posedge pclk);
    chk("rst_out", 32'h2, 32'({txc | rxc | cc, elec_idle, sync_status | irq}));
    presetn <= 1'b1;
    apb(0, `OFF_CTRL, 0);
    chk("ctrl_rst", 32'h0, rdat);
    apb(0, 12'h010, 0);
    chk("unmapped", 32'h1, 32'(rerr));
    apb(1, `OFF_IRQ_MASK, 32'h1);
    apb(0, `OFF_IRQ_MASK, 0);
    chk("mask", 32'h1, rdat);
    // idle follows inverted detect, then the three fabric clocks toggle together
    settle(8);
    chk("idle_det1", 32'h0, 32'(elec_idle));
    @(posedge pclk);
    sig_detect <= 1'b0;
    settle(8);
    chk("idle_det0", 32'h1, 32'(elec_idle));
    @(posedge pclk);
    sig_detect <= 1'b1;
    settle(8);
    chk("idle_det1b", 32'h0, 32'(elec_idle));
    k = txc;
    settle(1);
    chk("clk_out", {29'h0, ~k[0], ~k[0], ~k[0]}, {29'h0, txc, rxc, cc});
    // an error in mid-search restarts the comma count
    repeat (3) m.grp(1'b1, `SYM_COM, 1'b0);
    tsym(8'h00, 1'b1);
    repeat (3) m.grp(1'b1, `SYM_COM, 1'b0);
    settle(4);
    chk("sync_3", 32'h0, 32'(sync_status));
    m.grp(1'b1, `SYM_COM, 1'b0);
    #1;
    chk("sync_early", 32'h0, 32'(sync_status));
    settle(1);
    chk("sync_4", 32'h1, 32'(sync_status));
    settle(3);
    chk("irq_up", 32'h1, 32'(irq));
    apb(1, `OFF_IRQ_STAT, 32'h1);
    settle(3);
    chk("irq_clr", 32'h0, 32'(irq));
    // error count: up by errors, down per sixteen good groups
    repeat (5) tsym(8'($urandom), 1'b1);
    repeat (16) tsym(8'($urandom), 1'b0);
    settle(2);
    apb(0, `OFF_STATUS, 0);
    chk("errcnt", 32'h4, 32'(rdat[8:4]));
    repeat (12) tsym(8'h3C, 1'b1);
    settle(1);
    chk("sync_16", 32'h1, 32'(sync_status));
    tsym(8'h3C, 1'b1);
    settle(1);
    chk("sync_17", 32'h0, 32'(sync_status));
    apb(0, `OFF_STATUS, 0);
    chk("errcnt_clr", 32'h0, 32'(rdat[8:4]));
    chk("irq_masked", 32'h0, 32'(irq));
    // inference on: idle follows the lost sync, not the live detect
    apb(1, `OFF_CTRL, 32'h2);
    settle(2);
    chk("idle_infer", 32'h1, 32'(elec_idle));
    apb(1, `OFF_CTRL, 32'h0);
    ins_n = 0;
    del_n = 0;
    tset(1);
    settle(6);
    chk("rm_unsynced", 32'h0, 32'(ins_n + del_n));
    repeat (4) m.grp(1'b1, `SYM_COM, 1'b0);
    settle(12);
    apb(1, `OFF_IRQ_STAT, 32'h3F);
    // deletion with a nearly full fifo
    chk_en = 1;
    expq.delete();
    skp_out = 0;
    ins_n = 0;
    del_n = 0;
    out_ready <= 1'b0;
    repeat (5) tsym(8'($urandom), 1'b0);
    tset(2);
    settle(4);
    chk("del_once", 32'h1, 32'(del_n));
    @(posedge pclk);
    out_ready <= 1'b1;
    settle(16);
    chk("del_skips", 32'h1, 32'(skp_out));
    chk("del_no_ins", 32'h0, 32'(ins_n));
    apb(0, `OFF_IRQ_STAT, 0);
    chk("irq_del", 32'h1, 32'(rdat[`EV_DEL]));
    // insertion with a nearly empty fifo
    skp_out = 0;
    tset(1);
    settle(12);
    chk("ins_once", 32'h1, 32'(ins_n));
    chk("ins_skips", 32'h2, 32'(skp_out));
    // random traffic against random fabric stalls
    repeat (40) begin
      tsym(8'($urandom), 1'b0);
      out_ready <= ($urandom % 4) != 0;
      m.gap(1);
    end
    out_ready <= 1'b1;
    settle(20);
    chk("drained", 32'h0, 32'(expq.size()));
    // bypass: fifo frozen, symbols pass one cycle later, no events
    apb(1, `OFF_CTRL, 32'h1);
    skp_out = 0;
    ins_n = 0;
    del_n = 0;
    out_ready <= 1'b0;
    repeat (3) tsym(8'($urandom), 1'b0);
    tset(1);
    settle(3);
    chk("byp_left", 32'h0, 32'(expq.size()));
    chk("byp_skips", 32'h1, 32'(skp_out + ins_n + del_n));
    give_verdict();
  end
endmodule : tb_top
